/* eba_error_bank_regs.sv */
`timescale 1ns/1ps
module eba_error_bank_regs
  import eba_pkg::*;
#(
  parameter int unsigned NUM_THREADS = eba_pkg::EBA_NUM_THREADS,
  parameter logic [eba_pkg::EBA_NUM_BANKS-1:0] ADDR_IMPL = 3'h7,
  parameter logic [eba_pkg::EBA_NUM_BANKS-1:0] EXTRA_IMPL = 3'h7
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic msr_req,
  input wire logic msr_write,
  input wire logic [$clog2(NUM_THREADS)-1:0] msr_thread,
  input wire logic [eba_pkg::EBA_INDEX_W-1:0] msr_index,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] msr_wdata,
  output logic msr_done,
  output logic [eba_pkg::EBA_DATA_W-1:0] msr_rdata,
  output logic msr_gp_fault,
  input wire logic err_capture,
  input wire logic [1:0] err_bank,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] err_status,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] err_addr,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] err_extra
);
  import eba_pkg::*;

  typedef struct packed {
    logic [NUM_THREADS-1:0][EBA_PTR_W-1:0] trace_ptr;
    logic done;
    logic gp_fault;
    logic [EBA_DATA_W-1:0] rdata;
  } eba_top_s;

  typedef struct packed {
    logic hit;
    logic ptr;
    logic [1:0] bank;
    eba_sel_e sel;
  } eba_dec_s;

  eba_top_s st_reg;
  eba_top_s st_next;

  logic [EBA_NUM_BANKS-1:0] bank_wr;
  logic [EBA_NUM_BANKS-1:0] bank_cap;
  logic [EBA_NUM_BANKS-1:0][EBA_DATA_W-1:0] b_ctl;
  logic [EBA_NUM_BANKS-1:0][EBA_DATA_W-1:0] b_stat;
  logic [EBA_NUM_BANKS-1:0][EBA_DATA_W-1:0] b_addr;
  logic [EBA_NUM_BANKS-1:0][EBA_DATA_W-1:0] b_extra;

  logic hit_bank;
  logic hit_ptr;
  logic [1:0] bank_num;
  eba_sel_e sel;
  logic thread_ok;
  logic refuse;
  eba_dec_s dec;

  function automatic eba_dec_s bank_decode(input logic [EBA_INDEX_W-1:0] idx);
    eba_dec_s d;
    // unlisted indices stay unmapped, so they fault
    d = '{hit: 1'b0, ptr: 1'b0, bank: 2'h0, sel: EBA_SEL_CONTROL};
    if (idx == EBA_BANK1_CONTROL) begin
      d.hit = 1'b1;
      d.bank = 2'h0;
      d.sel = EBA_SEL_CONTROL;
    end else if (idx == EBA_BANK1_STATUS) begin
      d.hit = 1'b1;
      d.bank = 2'h0;
      d.sel = EBA_SEL_STATUS;
    end else if (idx == EBA_BANK1_ERROR_ADDRESS) begin
      d.hit = 1'b1;
      d.bank = 2'h0;
      d.sel = EBA_SEL_ADDRESS;
    end else if (idx == EBA_BANK1_ERROR_EXTRA_INFO) begin
      d.hit = 1'b1;
      d.bank = 2'h0;
      d.sel = EBA_SEL_EXTRA;
    end else if (idx == EBA_BANK2_ERROR_CONTROL) begin
      d.hit = 1'b1;
      d.bank = 2'h1;
      d.sel = EBA_SEL_CONTROL;
    end else if (idx == EBA_BANK2_ERROR_STATUS) begin
      d.hit = 1'b1;
      d.bank = 2'h1;
      d.sel = EBA_SEL_STATUS;
    end else if (idx == EBA_BANK2_ERROR_ADDRESS) begin
      d.hit = 1'b1;
      d.bank = 2'h1;
      d.sel = EBA_SEL_ADDRESS;
    end else if (idx == EBA_BANK2_ERROR_EXTRA_INFO) begin
      d.hit = 1'b1;
      d.bank = 2'h1;
      d.sel = EBA_SEL_EXTRA;
    end else if (idx == EBA_BANK3_ERROR_CONTROL) begin
      d.hit = 1'b1;
      d.bank = 2'h2;
      d.sel = EBA_SEL_CONTROL;
    end else if (idx == EBA_BANK3_ERROR_STATUS) begin
      d.hit = 1'b1;
      d.bank = 2'h2;
      d.sel = EBA_SEL_STATUS;
    end else if (idx == EBA_BANK3_ERROR_ADDRESS) begin
      d.hit = 1'b1;
      d.bank = 2'h2;
      d.sel = EBA_SEL_ADDRESS;
    end else if (idx == EBA_BANK3_ERROR_EXTRA_INFO) begin
      d.hit = 1'b1;
      d.bank = 2'h2;
      d.sel = EBA_SEL_EXTRA;
    end else if (idx == EBA_TRACE_AREA_POINTER) begin
      d.ptr = 1'b1;
    end
    bank_decode = d;
  endfunction

  always_comb begin
    dec = bank_decode(msr_index);
    hit_bank = dec.hit;
    hit_ptr = dec.ptr;
    bank_num = dec.bank;
    sel = dec.sel;
    thread_ok = (32'(msr_thread) < NUM_THREADS);
    refuse = 1'b0;
    if (!hit_bank && !hit_ptr) begin
      refuse = 1'b1;
    end else if (hit_ptr && !thread_ok) begin
      refuse = 1'b1;
    end else if (hit_bank && sel == EBA_SEL_ADDRESS && !ADDR_IMPL[bank_num]) begin
      refuse = 1'b1;
    end else if (hit_bank && sel == EBA_SEL_EXTRA && !EXTRA_IMPL[bank_num]) begin
      refuse = 1'b1;
    end
  end

  // one bank set, no thread select
  genvar gi;
  generate
    for (gi = 0; gi < EBA_NUM_BANKS; gi++) begin : g_bank
      assign bank_wr[gi] = msr_req && msr_write && hit_bank && !refuse
                           && (bank_num == 2'(gi));
      assign bank_cap[gi] = err_capture && (err_bank == 2'(gi + 1));
      eba_err_bank u_bank (
        .mclk(mclk),
        .reset_n(reset_n),
        .wr_en(bank_wr[gi]),
        .wr_sel(sel),
        .wr_data(msr_wdata),
        .cap_valid(bank_cap[gi]),
        .cap_status(err_status),
        .cap_addr(err_addr),
        .cap_extra(err_extra),
        .control(b_ctl[gi]),
        .status(b_stat[gi]),
        .address(b_addr[gi]),
        .extra(b_extra[gi])
      );
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.done = msr_req;
    st_next.gp_fault = msr_req && refuse;
    st_next.rdata = EBA_RESET_VALUE;
    if (msr_req && !refuse) begin
      if (hit_ptr) begin
        if (msr_write) begin
          // high half is reserved, dropped on write
          st_next.trace_ptr[msr_thread] = msr_wdata[EBA_PTR_W-1:0];
        end else begin
          st_next.rdata = {{(EBA_DATA_W-EBA_PTR_W){1'b0}}, st_reg.trace_ptr[msr_thread]};
        end
      end else if (!msr_write) begin
        case (sel)
          EBA_SEL_CONTROL: st_next.rdata = b_ctl[bank_num];
          EBA_SEL_STATUS: st_next.rdata = b_stat[bank_num];
          EBA_SEL_ADDRESS: begin
            if (b_stat[bank_num][EBA_ADDRESS_VALID_BIT]) begin
              st_next.rdata = b_addr[bank_num];
            end
          end
          default: begin
            if (b_stat[bank_num][EBA_EXTRA_INFO_VALID_BIT]) begin
              st_next.rdata = b_extra[bank_num];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.trace_ptr <= {NUM_THREADS{EBA_PTR_RESET}};
      st_reg.done <= 1'b0;
      st_reg.gp_fault <= 1'b0;
      st_reg.rdata <= EBA_RESET_VALUE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign msr_done = st_reg.done;
  assign msr_gp_fault = st_reg.gp_fault;
  assign msr_rdata = st_reg.rdata;

endmodule

/* eba_pkg.sv */
package eba_pkg;

  localparam int unsigned EBA_DATA_W = 64;
  localparam int unsigned EBA_INDEX_W = 32;
  localparam int unsigned EBA_NUM_BANKS = 3;
  localparam int unsigned EBA_NUM_THREADS = 2;
  localparam int unsigned EBA_PTR_W = 32;

  // register indices
  localparam logic [31:0] EBA_BANK1_CONTROL = 32'h0000_0404;
  localparam logic [31:0] EBA_BANK1_STATUS = 32'h0000_0405;
  localparam logic [31:0] EBA_BANK1_ERROR_ADDRESS = 32'h0000_0406;
  localparam logic [31:0] EBA_BANK1_ERROR_EXTRA_INFO = 32'h0000_0407;
  localparam logic [31:0] EBA_BANK2_ERROR_CONTROL = 32'h0000_0408;
  localparam logic [31:0] EBA_BANK2_ERROR_STATUS = 32'h0000_0409;
  localparam logic [31:0] EBA_BANK2_ERROR_ADDRESS = 32'h0000_040a;
  localparam logic [31:0] EBA_BANK2_ERROR_EXTRA_INFO = 32'h0000_040b;
  localparam logic [31:0] EBA_BANK3_ERROR_CONTROL = 32'h0000_040c;
  localparam logic [31:0] EBA_BANK3_ERROR_STATUS = 32'h0000_040d;
  localparam logic [31:0] EBA_BANK3_ERROR_ADDRESS = 32'h0000_040e;
  localparam logic [31:0] EBA_BANK3_ERROR_EXTRA_INFO = 32'h0000_040f;
  localparam logic [31:0] EBA_TRACE_AREA_POINTER = 32'h0000_0600;

  // bank window: four registers per bank, banks back to back
  localparam logic [31:0] EBA_BANK_BASE = EBA_BANK1_CONTROL;
  localparam logic [31:0] EBA_BANK_LAST = EBA_BANK3_ERROR_EXTRA_INFO;
  localparam int unsigned EBA_SEL_W = 2;

  typedef enum logic [1:0] {
    EBA_SEL_CONTROL,
    EBA_SEL_STATUS,
    EBA_SEL_ADDRESS,
    EBA_SEL_EXTRA
  } eba_sel_e;

  // flag positions inside bank_error_status
  localparam int unsigned EBA_ADDRESS_VALID_BIT = 58;
  localparam int unsigned EBA_EXTRA_INFO_VALID_BIT = 59;

  localparam logic [63:0] EBA_RESET_VALUE = 64'h0;
  localparam logic [31:0] EBA_PTR_RESET = 32'h0;

endpackage

/* eba_err_bank.sv */
`timescale 1ns/1ps
module eba_err_bank
  import eba_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire eba_pkg::eba_sel_e wr_sel,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] wr_data,
  input wire logic cap_valid,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] cap_status,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] cap_addr,
  input wire logic [eba_pkg::EBA_DATA_W-1:0] cap_extra,
  output logic [eba_pkg::EBA_DATA_W-1:0] control,
  output logic [eba_pkg::EBA_DATA_W-1:0] status,
  output logic [eba_pkg::EBA_DATA_W-1:0] address,
  output logic [eba_pkg::EBA_DATA_W-1:0] extra
);
  import eba_pkg::*;

  typedef struct packed {
    logic [EBA_DATA_W-1:0] control;
    logic [EBA_DATA_W-1:0] status;
    logic [EBA_DATA_W-1:0] address;
    logic [EBA_DATA_W-1:0] extra;
  } eba_bank_s;

  eba_bank_s st_reg;
  eba_bank_s st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      case (wr_sel)
        EBA_SEL_CONTROL: st_next.control = wr_data;
        EBA_SEL_STATUS: st_next.status = wr_data;
        EBA_SEL_ADDRESS: st_next.address = wr_data;
        default: st_next.extra = wr_data;
      endcase
    end
    // capture after the write: a logged error wins over a same-cycle write to status, and to address or extra when its valid flag is set
    if (cap_valid) begin
      st_next.status = cap_status;
      if (cap_status[EBA_ADDRESS_VALID_BIT]) begin
        st_next.address = cap_addr;
      end
      if (cap_status[EBA_EXTRA_INFO_VALID_BIT]) begin
        st_next.extra = cap_extra;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{default: EBA_RESET_VALUE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign control = st_reg.control;
  assign status = st_reg.status;
  assign address = st_reg.address;
  assign extra = st_reg.extra;

endmodule

/* eba_error_bank_regs_sva.sv */
`timescale 1ns/1ps
module eba_regs_sva
  import eba_pkg::*;
#(
  parameter int unsigned NUM_THREADS = 2,
  parameter logic [2:0] ADDR_IMPL = 3'h7,
  parameter logic [2:0] EXTRA_IMPL = 3'h7
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic msr_req,
  input wire logic msr_write,
  input wire logic [$clog2(NUM_THREADS)-1:0] msr_thread,
  input wire logic [31:0] msr_index,
  input wire logic [63:0] msr_wdata,
  input wire logic msr_done,
  input wire logic [63:0] msr_rdata,
  input wire logic msr_gp_fault,
  input wire logic err_capture,
  input wire logic [1:0] err_bank,
  input wire logic [63:0] err_status,
  input wire logic [63:0] err_addr,
  input wire logic [63:0] err_extra
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic in_bank = msr_index[31:4] == 28'h40 && msr_index[3:2] != 2'h0;
  wire logic [1:0] bk = msr_index[3:2] - 2'h1;
  wire logic mapped = in_bank || msr_index == 32'h600;
  wire logic unimpl = in_bank && ((msr_index[1:0] == 2'h2 && !ADDR_IMPL[bk])
    || (msr_index[1:0] == 2'h3 && !EXTRA_IMPL[bk]));
  sequence s_ptr_wr;
    msr_req && msr_write && msr_index == 32'h600;
  endsequence
  sequence s_ptr_rd;
    msr_req && !msr_write && msr_index == 32'h600;
  endsequence
  sequence s_ctl_wr;
    msr_req && msr_write && in_bank && msr_index[1:0] == 2'h0;
  endsequence
  property p_done; msr_done == $past(msr_req); endproperty
  a_done: assert property (p_done) else $error("done not one cycle after request");
  property p_unmapped; msr_req && !mapped |=> msr_gp_fault; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index not refused");
  property p_mapped; msr_req && mapped && !unimpl |=> !msr_gp_fault; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped index refused");
  property p_unimpl; msr_req && unimpl |=> msr_gp_fault && msr_rdata == 64'h0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("missing register not faulted");
  property p_ptr_hi; s_ptr_rd |=> msr_rdata[63:32] == 32'h0; endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer upper half not zero");
  property p_ptr_keep;
    s_ptr_wr ##1 (s_ptr_rd and msr_thread == $past(msr_thread))
      |=> msr_rdata == ($past(msr_wdata, 2) & 64'hffff_ffff);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer not kept");
  property p_ptr_private;
    s_ptr_wr ##1 (s_ptr_wr and msr_thread != $past(msr_thread))
      ##1 (s_ptr_rd and msr_thread == $past(msr_thread, 2))
      |=> msr_rdata == ($past(msr_wdata, 3) & 64'hffff_ffff);
  endproperty
  a_ptr_private: assert property (p_ptr_private) else $error("pointer copy shared");
  property p_shared;
    s_ctl_wr ##1 (msr_req && !msr_write && msr_index == $past(msr_index)
      && msr_thread != $past(msr_thread)) |=> msr_rdata == $past(msr_wdata, 2);
  endproperty
  a_shared: assert property (p_shared) else $error("bank register not shared");
  property p_addr_flag;
    err_capture && err_bank == 2'h1 && !err_status[58]
      ##1 (msr_req && !msr_write && !err_capture && msr_index == 32'h406)
      |=> msr_rdata == 64'h0;
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("address shown without flag");
  property p_extra_flag;
    err_capture && err_bank == 2'h1 && !err_status[59]
      ##1 (msr_req && !msr_write && !err_capture && msr_index == 32'h407)
      |=> msr_rdata == 64'h0;
  endproperty
  a_extra_flag: assert property (p_extra_flag) else $error("extra shown without flag");
endmodule

bind eba_error_bank_regs eba_regs_sva #(.NUM_THREADS(NUM_THREADS), .ADDR_IMPL(ADDR_IMPL),
  .EXTRA_IMPL(EXTRA_IMPL)) u_sva (.mclk(mclk), .reset_n(reset_n), .msr_req(msr_req),
  .msr_write(msr_write), .msr_thread(msr_thread), .msr_index(msr_index),
  .msr_wdata(msr_wdata), .msr_done(msr_done), .msr_rdata(msr_rdata),
  .msr_gp_fault(msr_gp_fault), .err_capture(err_capture), .err_bank(err_bank),
  .err_status(err_status), .err_addr(err_addr), .err_extra(err_extra));

/* eba_error_bank_regs_test.sv */
`timescale 1ns/1ps
module eba_error_bank_regs_test;
  import eba_pkg::*;
  logic mclk = 0, reset_n = 0, msr_req = 0, msr_write = 0, msr_thread = 0, err_capture = 0;
  logic [31:0] msr_index = 0;
  logic [63:0] msr_wdata = 0, err_status = 0, err_addr = 0, err_extra = 0;
  logic [1:0] err_bank = 0;
  wire logic msr_done, msr_gp_fault;
  wire logic [63:0] msr_rdata;
  int mismatches = 0, compares = 0, cycles = 0;
  int bad [3] = '{'h403, 'h410, 'h601};
  always #4 mclk = ~mclk;
  // bank2 address and bank3 extra left out so refusals are reachable
  eba_error_bank_regs #(.NUM_THREADS(2), .ADDR_IMPL(3'h5), .EXTRA_IMPL(3'h3)) dut (
    .mclk(mclk), .reset_n(reset_n), .msr_req(msr_req), .msr_write(msr_write),
    .msr_thread(msr_thread), .msr_index(msr_index), .msr_wdata(msr_wdata),
    .msr_done(msr_done), .msr_rdata(msr_rdata), .msr_gp_fault(msr_gp_fault),
    .err_capture(err_capture), .err_bank(err_bank), .err_status(err_status),
    .err_addr(err_addr), .err_extra(err_extra));
  task final_report;
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 400) begin
      mismatches++;
      $display("unexpected %0t timeout", $time);
      final_report;
    end
  end
  task acc(input logic t, w, input logic [31:0] i, input logic [63:0] d, e, input logic g);
    msr_req = 1;
    msr_write = w;
    msr_thread = t;
    msr_index = i;
    msr_wdata = d;
    @(negedge mclk);
    compares++;
    if (msr_done !== 1'b1 || msr_gp_fault !== g || msr_rdata !== e) begin
      mismatches++;
      $display("unexpected %0t index %h rdata %h fault %b", $time, i, msr_rdata, msr_gp_fault);
    end
  endtask
  task idle;
    msr_req = 0;
    @(negedge mclk);
  endtask
  task cap(input logic [1:0] b, input logic [63:0] s, a, x);
    err_capture = 1;
    err_bank = b;
    err_status = s;
    err_addr = a;
    err_extra = x;
    @(negedge mclk);
    err_capture = 0;
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    reset_n = 1;
    for (int i = 'h404; i <= 'h40f; i++) acc(0, 0, i, 0, 0, i == 'h40a || i == 'h40f);
    acc(1, 0, 'h600, 0, 0, 0);
    foreach (bad[k]) acc(k[0], k[1], bad[k], '1, 0, 1);
    acc(0, 1, 'h40a, '1, 0, 1);
    acc(1, 1, 'h40f, '1, 0, 1);
    acc(0, 1, 'h600, 64'hffff_0000_1234_5678, 0, 0);
    acc(1, 1, 'h600, 64'h0000_0001_9abc_def0, 0, 0);
    acc(0, 0, 'h600, 0, 64'h1234_5678, 0);
    acc(1, 0, 'h600, 0, 64'h9abc_def0, 0);
    acc(0, 1, 'h600, 64'h8765_4321, 0, 0);
    acc(0, 0, 'h600, 0, 64'h8765_4321, 0);
    acc(0, 1, 'h408, 64'ha5a5_0000_0000_5a5a, 0, 0);
    acc(1, 0, 'h408, 0, 64'ha5a5_0000_0000_5a5a, 0);
    acc(1, 1, 'h40c, 64'h1, 0, 0);
    acc(0, 0, 'h40c, 0, 64'h1, 0);
    idle;
    cap(1, 64'h0400_0000_0000_0001, 64'h1122, 64'h3344);
    acc(0, 0, 'h407, 0, 0, 0);
    acc(0, 0, 'h406, 0, 64'h1122, 0);
    acc(1, 0, 'h405, 0, 64'h0400_0000_0000_0001, 0);
    idle;
    cap(1, 64'h0800_0000_0000_0000, 64'h55, 64'h66);
    acc(0, 0, 'h406, 0, 0, 0);
    acc(0, 0, 'h407, 0, 64'h66, 0);
    // logged error and software write in one cycle: the capture wins
    err_capture = 1;
    err_status = 64'h0400_0000_0000_00ff;
    err_addr = 64'h99;
    acc(0, 1, 'h406, 64'hdead, 0, 0);
    err_capture = 0;
    acc(0, 0, 'h406, 0, 64'h99, 0);
    idle;
    cap(2, 64'h0c00_0000_0000_0000, 64'h77, 64'h88);
    acc(1, 0, 'h40b, 0, 64'h88, 0);
    acc(1, 0, 'h40a, 0, 0, 1);
    idle;
    cap(0, 64'h0c00_0000_0000_0000, 64'h1, 64'h2);
    acc(0, 0, 'h40d, 0, 0, 0);
    idle;
    final_report;
  end
endmodule
